/* File: core/smb_cfg_slave.sv */
`include "smb_cfg_params.svh"
`default_nettype none
module smb_cfg_slave
	import smb_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Bus pins (open drain, oe low while pulling low)
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Straps
	input  wire logic [2:0] addr_strap_pin,
	input  wire logic [1:0] pll_mode_strap,
	// Output enable pins, active low
	input  wire logic [1:0] out_enable_pin_n,
	// Stop-control field from the stop-control register
	input  wire logic [1:0] disable_state_field,
	// Configuration to the clock core
	output cfg_out_t        cfg
);
	typedef struct packed {
		logic [1:0] strap_cnt;
		logic [1:0][1:0] oe_pin_s;
		logic [1:0][2:0] addr_pin_s;
		logic [1:0][1:0] mode_pin_s;
		logic [2:0] addr_lo;
		logic [1:0] pll_latched;
		logic [7:0] out_enable_ctrl;
		logic [7:0] pll_mode_amplitude_ctrl;
		phase_t     phase;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] index;
		logic [7:0] remain;
		logic       ack_slot;
		logic       drive_low;
		logic       got_count;
		cfg_out_t   cfg;
	} state_t;
	state_t st, next_st;
	line_ev_t ev;
	logic [7:0] rd_byte;

	// ----------------------------------------
	// Line front end
	// ----------------------------------------
	smb_line_sync smb_line_sync_i (
		.clock  (clock),
		.rst    (rst),
		.scl_in (scl_in),
		.sda_in (sda_in),
		.ev     (ev)
	);

	// ----------------------------------------
	// Register readback
	// ----------------------------------------
	// Register readback mux
	always_comb begin
		case (st.index)
			`REG_OUT_ENABLE: rd_byte = st.out_enable_ctrl;
			`REG_PLL_MODE:   rd_byte = {st.pll_latched, st.pll_mode_amplitude_ctrl[5:0]};
			default:         rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// Pins pass two flip-flops before any logic reads them
		// Straps are static, but a raw pin must never reach logic
		next_st.oe_pin_s   = {st.oe_pin_s[0], out_enable_pin_n};
		next_st.addr_pin_s = {st.addr_pin_s[0], addr_strap_pin};
		next_st.mode_pin_s = {st.mode_pin_s[0], pll_mode_strap};
		// Strap capture a few cycles after reset release
		if (st.strap_cnt != 2'h3) begin
			next_st.strap_cnt = st.strap_cnt + 2'h1;
			if (st.strap_cnt == 2'h2) begin
				next_st.addr_lo     = st.addr_pin_s[1];
				next_st.pll_latched = st.mode_pin_s[1];
			end
		end
		if (ev.start) begin
			next_st.phase     = PH_ADDR;
			next_st.bitcnt    = 4'h0;
			next_st.ack_slot  = 1'b0;
			next_st.drive_low = 1'b0;
		end else if (ev.stop) begin
			next_st.phase     = PH_IDLE;
			next_st.drive_low = 1'b0;
		end else if (st.phase != PH_IDLE && st.phase != PH_SKIP) begin
			if (ev.rise && !st.ack_slot) begin
				next_st.shift  = {st.shift[6:0], ev.sda};
				next_st.bitcnt = st.bitcnt + 4'h1;
			end
			// Host nack ends the read; idle until stop or start
			if (ev.rise && st.ack_slot && st.phase == PH_RDATA && ev.sda) begin
				next_st.phase = PH_SKIP;
			end
			if (ev.fall) begin
				if (st.ack_slot) begin
					// Acknowledge slot over; prepare next byte
					next_st.ack_slot  = 1'b0;
					next_st.bitcnt    = 4'h0;
					next_st.drive_low = 1'b0;
					if (st.phase == PH_RDATA) begin
						// Count byte first, then register data from N onward
						next_st.shift     = st.got_count ? rd_byte : st.remain;
						next_st.drive_low = st.got_count ? ~rd_byte[7] : ~st.remain[7];
						if (st.got_count) begin
							next_st.index = st.index + 8'h1;
						end
						next_st.got_count = 1'b1;
					end
				end else if (st.bitcnt == 4'h8) begin
					// Eighth bit done: the next low phase is the ack slot
					next_st.ack_slot = 1'b1;
					next_st.drive_low = (st.phase != PH_RDATA);
					case (st.phase)
						PH_ADDR: begin
							// Match: index follows for writes, count for reads
							if (st.shift[7:1] == {`ADDR_UPPER, st.addr_lo}) begin
								next_st.phase     = st.shift[0] ? PH_RDATA : PH_INDEX;
								next_st.got_count = 1'b0;
								next_st.remain    = `REG_COUNT - st.index;
							end else begin
								next_st.phase     = PH_SKIP;
								next_st.drive_low = 1'b0;
							end
						end
						PH_INDEX: begin
							next_st.index = st.shift;
							next_st.phase = PH_COUNT;
						end
						PH_COUNT: begin
							next_st.remain = st.shift;
							next_st.phase  = PH_WDATA;
						end
						PH_WDATA: begin
							// Store into N.. while count lasts; reserved bits kept
							if (st.remain != 8'h00) begin
								case (st.index)
									`REG_OUT_ENABLE: next_st.out_enable_ctrl =
										(st.out_enable_ctrl & ~`OUT_ENABLE_RW) |
										(st.shift & `OUT_ENABLE_RW);
									`REG_PLL_MODE: next_st.pll_mode_amplitude_ctrl =
										(st.pll_mode_amplitude_ctrl & ~`PLL_MODE_RW) |
										(st.shift & `PLL_MODE_RW);
									default: ;
								endcase
								next_st.remain = st.remain - 8'h1;
								next_st.index  = st.index + 8'h1;
							end
						end
						PH_RDATA: ;
						default: ;
					endcase
				end else if (st.phase == PH_RDATA) begin
					// Each rise shifted once, so the next read bit is on top
					next_st.drive_low = ~st.shift[7];
				end
			end
		end

		// Decode configuration for the clock core
		next_st.cfg.out_active[1] = st.out_enable_ctrl[`BIT_OUT1_ENABLE] &
			~st.oe_pin_s[1][1];
		next_st.cfg.out_active[0] = st.out_enable_ctrl[`BIT_OUT0_ENABLE] &
			~st.oe_pin_s[1][0];
		next_st.cfg.pll_mode = st.pll_mode_amplitude_ctrl[`BIT_SW_SELECT] ?
			st.pll_mode_amplitude_ctrl[4:3] : st.pll_latched;
		next_st.cfg.swing_sel = st.pll_mode_amplitude_ctrl[1:0];
		next_st.cfg.disable_state_field = disable_state_field;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// All block state except the line front end in one register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '{strap_cnt: 2'h0, oe_pin_s: 4'hF, addr_pin_s: 6'h00, mode_pin_s: 4'h0,
				addr_lo: 3'h0, pll_latched: 2'h0,
				out_enable_ctrl: `OUT_ENABLE_RESET,
				pll_mode_amplitude_ctrl: `PLL_MODE_RESET,
				phase: PH_IDLE, bitcnt: 4'h0, shift: 8'h00,
				index: 8'h00, remain: 8'h00, ack_slot: 1'b0, drive_low: 1'b0,
				got_count: 1'b0,
				cfg: '{out_active: 2'h0, pll_mode: 2'h0, swing_sel: 2'h2,
					disable_state_field: `DISABLE_STATE_RESET}};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Open-drain data pin
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~st.drive_low;
	assign cfg      = st.cfg;
endmodule
`default_nettype wire

/* File: core/smb_cfg_params.svh */
`ifndef SMB_CFG_PARAMS_SVH
`define SMB_CFG_PARAMS_SVH
// ----------------------------------------
// Address and register map
// ----------------------------------------
`define ADDR_UPPER        4'hD
`define REG_OUT_ENABLE    8'h00
`define REG_PLL_MODE      8'h01
`define REG_COUNT         8'h02
`define OUT_ENABLE_RESET  8'h18
`define PLL_MODE_RESET    8'h06
`define OUT_ENABLE_RW     8'h18
`define PLL_MODE_RW       8'h3B
`define BIT_OUT1_ENABLE   4
`define BIT_OUT0_ENABLE   3
`define BIT_SW_SELECT     5
`define DISABLE_STATE_RESET 2'h0
`endif

/* File: core/smb_cfg_pkg.sv */
`default_nettype none
package smb_cfg_pkg;
	// Byte-level phases of a transaction
	typedef enum logic [6:0] {
		PH_IDLE  = 7'h01,
		PH_ADDR  = 7'h02,
		PH_INDEX = 7'h04,
		PH_COUNT = 7'h08,
		PH_WDATA = 7'h10,
		PH_RDATA = 7'h20,
		PH_SKIP  = 7'h40
	} phase_t;

	// Bit events from the line front end
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} line_ev_t;

	// Configuration outputs toward the analog core
	typedef struct packed {
		logic [1:0] out_active;
		logic [1:0] pll_mode;
		logic [1:0] swing_sel;
		logic [1:0] disable_state_field;
	} cfg_out_t;
endpackage
`default_nettype wire

/* File: core/smb_line_sync.sv */
`default_nettype none
module smb_line_sync
	import smb_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Raw bus pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Events
	output line_ev_t  ev
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_d;
		logic       sda_d;
	} sync_t;
	sync_t st, next_st;

	// Two-stage synchronisers, then one delayed copy for edges
	always_comb begin
		next_st       = st;
		next_st.scl_s = {st.scl_s[0], scl_in};
		next_st.sda_s = {st.sda_s[0], sda_in};
		next_st.scl_d = st.scl_s[1];
		next_st.sda_d = st.sda_s[1];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	// Edge and condition decode from settled samples only
	always_comb begin
		ev.rise  = st.scl_s[1] & ~st.scl_d;
		ev.fall  = ~st.scl_s[1] & st.scl_d;
		ev.start = st.scl_s[1] & st.scl_d & st.sda_d & ~st.sda_s[1];
		ev.stop  = st.scl_s[1] & st.scl_d & ~st.sda_d & st.sda_s[1];
		ev.sda   = st.sda_s[1];
	end
endmodule
`default_nettype wire

/* File: testbench/smb_cfg_asserts.sv */
`default_nettype none
module smb_cfg_asserts
	import smb_cfg_pkg::*;
(
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Bus and straps
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic [2:0] addr_strap_pin,
	input wire logic [1:0] pll_mode_strap,
	// Output control
	input wire logic [1:0] out_enable_pin_n,
	input wire logic [1:0] disable_state_field,
	input wire cfg_out_t   cfg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pull_clk_low: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("pull started with clock high");
	a_ack_stands: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
		else $error("pull released early");
	a_pull_bounded: assert property ($fell(sda_oe_n) |-> ##[1:80] $rose(sda_oe_n))
		else $error("pull held too long");
	a_swing_reset: assert property ($fell(rst) |-> cfg.swing_sel == 2'b10)
		else $error("swing not at reset value");
	a_strap_mode: assert property ($fell(rst) |-> ##8 cfg.pll_mode == pll_mode_strap)
		else $error("pll mode not from strap");
	a_out1_pin_off: assert property (out_enable_pin_n[1] [*4] |-> !cfg.out_active[1])
		else $error("out1 active with pin off");
	a_out0_pin_off: assert property (out_enable_pin_n[0] [*4] |-> !cfg.out_active[0])
		else $error("out0 active with pin off");
	a_dis_follow: assert property ($stable(disable_state_field) [*4]
		|-> cfg.disable_state_field == disable_state_field)
		else $error("disable state not passed");
	// Main scenarios reached
	c_ack: cover property ($fell(sda_oe_n));
	c_sw_mode: cover property (cfg.pll_mode != pll_mode_strap);
	c_one_off: cover property (cfg.out_active == 2'b01);
endmodule

bind smb_cfg_slave smb_cfg_asserts smb_cfg_asserts_i (.clock, .rst, .scl_in, .sda_in,
	.sda_out, .sda_oe_n, .addr_strap_pin, .pll_mode_strap, .out_enable_pin_n,
	.disable_state_field, .cfg);
`default_nettype wire

/* File: testbench/smb_host_model.sv */
`default_nettype none
module smb_host_model
(
	// Bus lines, sda_drv high means released
	output logic     scl,
	output logic     sda_drv,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// One bit: data moves while clock low
	task automatic bit_x(input logic b, output logic s);
		sda_drv = b;
		#40 scl = 1'b1;
		#40 s = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	// Start or repeated start
	task automatic start();
		sda_drv = 1'b1;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b0;
		#40 scl = 1'b0;
		#40;
	endtask
	// Stop after a whole byte
	task automatic stop();
		sda_drv = 1'b0;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b1;
		#80;
	endtask
	// Byte out, MSB first, returns ack
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	// Byte in, nack on the last one
	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, s);
	endtask
endmodule
`default_nettype wire

/* File: testbench/smb_cfg_slave_tb_top.sv */
`default_nettype none
module smb_cfg_slave_tb_top
	import smb_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] DEV = 7'h6D; // Fixed 1101 plus strap 101
	logic      clock = 1'b0;
	logic      rst = 1'b1;
	logic [1:0] pin_n = 2'b00;
	logic [1:0] dis = 2'b10;
	logic [2:0] strap = 3'b101;
	logic [1:0] pmode = 2'b10;
	wire logic scl;
	wire logic host_sda;
	logic      sda_out;
	logic      sda_oe_n;
	cfg_out_t  cfg;
	int        err_count = 0;
	int        n_compared = 0;
	logic [7:0] c, a, b;
	// Wired-AND data line with pull-up
	wire logic sda = host_sda & (sda_oe_n | sda_out);
	always #10 clock = ~clock;
	smb_cfg_slave smb_cfg_slave_i (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_pin(strap),
		.pll_mode_strap(pmode), .out_enable_pin_n(pin_n), .disable_state_field(dis),
		.cfg(cfg));
	smb_host_model smb_host_model_i (.scl(scl), .sda_drv(host_sda), .sda(sda));
	task chk(input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wtx(input logic [6:0] ad, input logic [7:0] n, x, d0, d1, input int k, input logic ok);
		logic ack;
		smb_host_model_i.start();
		smb_host_model_i.wr({ad, 1'b0}, ack);
		chk(ack, ok);
		smb_host_model_i.wr(n, ack);
		smb_host_model_i.wr(x, ack);
		smb_host_model_i.wr(d0, ack);
		if (k > 1) smb_host_model_i.wr(d1, ack);
		chk(ack, ok);
		smb_host_model_i.stop();
		#200;
	endtask
	task rtx(input logic [6:0] ad);
		logic ack;
		smb_host_model_i.start();
		smb_host_model_i.wr({ad, 1'b0}, ack);
		smb_host_model_i.wr(8'h00, ack);
		smb_host_model_i.start();
		smb_host_model_i.wr({ad, 1'b1}, ack);
		chk(ack, 8'h01);
		smb_host_model_i.rd(1'b0, c);
		smb_host_model_i.rd(1'b0, a);
		smb_host_model_i.rd(1'b1, b);
		smb_host_model_i.stop();
		chk(c, 8'h02);
	endtask
	task t_powerup();
		rtx(DEV);
		chk(a, 8'h18);
		chk(b, 8'h86);
		chk(cfg, 8'hEA);
		$display("powerup done");
	endtask
	task t_write();
		wtx(DEV, 8'h00, 8'h02, 8'hE7, 8'hFF, 2, 1'b1);
		chk(cfg, 8'h3E);
		rtx(DEV);
		chk(a, 8'h00);
		chk(b, 8'hBF);
		$display("write done");
	endtask
	task t_sw_idle();
		wtx(DEV, 8'h01, 8'h01, 8'h18, 8'h00, 1, 1'b1);
		chk(cfg, 8'h22);
		rtx(DEV);
		chk(b, 8'h9C);
		$display("sw idle done");
	endtask
	task t_early();
		dis = 2'b00;
		wtx(DEV, 8'h00, 8'h02, 8'h18, 8'h00, 1, 1'b1);
		pin_n = 2'b10;
		#200;
		chk(cfg, 8'h60);
		wtx(7'h6C, 8'h00, 8'h01, 8'h00, 8'h00, 1, 1'b0);
		rtx(DEV);
		chk(a, 8'h18);
		$display("early stop done");
	endtask
	// New straps only count after a reset; old address must be ignored
	task t_restrap();
		strap = 3'b010;
		pmode = 2'b01;
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (8) @(negedge clock);
		wtx(DEV, 8'h00, 8'h01, 8'h00, 8'h00, 1, 1'b0);
		rtx(7'h6A);
		chk(a, 8'h18);
		chk(b, 8'h46);
		chk(cfg, 8'h58);
		$display("restrap done");
	endtask
	task report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (8) @(negedge clock);
		t_powerup();
		t_write();
		t_sw_idle();
		t_early();
		t_restrap();
		report_and_stop();
	end
	initial begin
		#1000000;
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
